// *** core/fan_lut_entry_ten.sv ***
// Lookup table entry ten: temperature limit and paired duty cycle
`timescale 1ns/1ps
`default_nettype none

module fan_lut_entry_ten #(
    parameter int TEMP_BITS = lut_entry_pkg::TEMP_W,
    parameter int DUTY_BITS = lut_entry_pkg::DUTY_W
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire lut_entry_pkg::reg_req_s req_in,
    input wire lut_entry_pkg::mode_s mode_in,
    input wire logic [8:0] remote_temp_in,
    input wire logic [8:0] table_offset_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    output logic above_out,
    output logic [7:0] duty_out
);
    // One guard bit so limit plus offset cannot wrap
    localparam int THR_W = TEMP_BITS + 1;
    localparam int TOP = lut_entry_pkg::THRESHOLD_TOP_POS;
    localparam int EXT = lut_entry_pkg::DUTY_EXT_LSB;
    localparam int BASE_W = lut_entry_pkg::DUTY_BASE_W;

    // Stored registers
    logic [7:0] limit_r;
    logic [7:0] limit_nxt;
    logic [7:0] duty_r;
    logic [7:0] duty_nxt;
    logic wr_take;

    // Read port
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic rd_take;

    // Compare path
    logic above_r;
    logic above_nxt;
    logic [7:0] duty_o_r;
    logic [7:0] duty_o_nxt;
    logic [THR_W-1:0] thr_base;
    logic [THR_W-1:0] thr_full;
    logic [THR_W-1:0] temp_cmp;

    // Masked views of the stored bits
    logic [7:0] limit_vis;
    logic [7:0] duty_vis;
    logic ext_ok;

    // Ports are sized for the register map, so other widths are refused
    if (TEMP_BITS != lut_entry_pkg::TEMP_W) begin : g_temp_width_check
        $error("TEMP_BITS must match the nine bit reading");
    end
    if (DUTY_BITS != lut_entry_pkg::DUTY_W) begin : g_duty_width_check
        $error("DUTY_BITS must match the eight bit register");
    end
    if (EXT != BASE_W) begin : g_duty_split_check
        $error("Duty extension must sit directly above the base bits");
    end

    // Register select, shared by write and read paths
    function automatic logic hits_limit(input logic [7:0] addr);
        hits_limit = (addr == lut_entry_pkg::TEMP_LIMIT_ADDR);
    endfunction

    function automatic logic hits_duty(input logic [7:0] addr);
        hits_duty = (addr == lut_entry_pkg::DUTY_CYCLE_ADDR);
    endfunction

    // Stored bits are kept; only what is read and used is masked
    always_comb begin
        ext_ok = mode_in.hi_res_duty & mode_in.pwm_22k5_sel;
        limit_vis = limit_r;
        if (!mode_in.hi_res_temp) begin
            limit_vis[TOP] = 1'b0;
        end
        duty_vis = duty_r;
        if (!ext_ok) begin
            duty_vis[7:EXT] = 2'b00;
        end
    end

    // Writes land only while the table is unlocked
    always_comb begin
        wr_take = req_in.wr & mode_in.table_wr_en;
        limit_nxt = limit_r;
        duty_nxt = duty_r;
        if (wr_take) begin
            if (hits_limit(req_in.addr)) begin
                limit_nxt = req_in.wdata;
            end else if (hits_duty(req_in.addr)) begin
                duty_nxt = req_in.wdata;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            limit_r <= lut_entry_pkg::TEMP_LIMIT_RESET;
            duty_r <= lut_entry_pkg::DUTY_CYCLE_RESET;
        end else begin
            limit_r <= limit_nxt;
            duty_r <= duty_nxt;
        end
    end

    // Reads are never gated; unknown addresses answer zero
    always_comb begin
        rd_take = req_in.rd;
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        if (rd_take) begin
            rvalid_nxt = 1'b1;
            if (hits_limit(req_in.addr)) begin
                rdata_nxt = limit_vis;
            end else if (hits_duty(req_in.addr)) begin
                rdata_nxt = duty_vis;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Both sides in half degrees; unsigned so never negative
    // Low resolution drops the half degree bit on both sides
    always_comb begin
        if (mode_in.hi_res_temp) begin
            thr_base = {2'b00, limit_vis};
            temp_cmp = {1'b0, remote_temp_in};
        end else begin
            thr_base = {2'b00, limit_vis[TOP-1:0], 1'b0};
            temp_cmp = {1'b0, remote_temp_in[8:1], 1'b0};
        end
        // Readings beyond nine bits cannot exist, so a high sum just never trips
        thr_full = thr_base + {1'b0, table_offset_in};
        above_nxt = temp_cmp > thr_full;
        duty_o_nxt = 8'h00;
        if (above_nxt) begin
            duty_o_nxt = duty_vis;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            above_r <= 1'b0;
            duty_o_r <= 8'h00;
        end else begin
            above_r <= above_nxt;
            duty_o_r <= duty_o_nxt;
        end
    end

    // Outputs straight from the flip-flops
    assign rdata_out = rdata_r;
    assign rvalid_out = rvalid_r;
    assign above_out = above_r;
    assign duty_out = duty_o_r;
endmodule // fan_lut_entry_ten

`default_nettype wire

// *** pkg/lut_entry_pkg.sv ***
// Package: register map, fields and reset values for one fan lookup table entry
package lut_entry_pkg;
    localparam logic [7:0] TEMP_LIMIT_ADDR = 8'h62;
    localparam logic [7:0] DUTY_CYCLE_ADDR = 8'h63;
    localparam logic [7:0] TEMP_LIMIT_RESET = 8'h7f;
    localparam logic [7:0] DUTY_CYCLE_RESET = 8'h3f;
    localparam int THRESHOLD_TOP_POS = 7;
    localparam int DUTY_EXT_LSB = 6;
    localparam int DUTY_BASE_W = 6;
    localparam int TEMP_W = 9;
    localparam int DUTY_W = 8;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic hi_res_temp;
        logic hi_res_duty;
        logic pwm_22k5_sel;
        logic table_wr_en;
    } mode_s;
endpackage

// *** tb/fan_lut_entry_ten_tb.sv ***
// Testbench for fan table entry ten
`timescale 1ns/1ps
`default_nettype none
module fan_lut_entry_ten_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    lut_entry_pkg::reg_req_s req = '0;
    lut_entry_pkg::mode_s md = '0;
    logic [8:0] temp = 9'h000;
    logic [8:0] ofs = 9'h000;
    logic [7:0] rd, duty;
    logic rv, ab;
    int num_errors = 0, checks_done = 0, cyc = 0;
    fan_lut_entry_ten fan_lut_entry_ten_i (.ref_clk_in(clk), .reset_in(rst), .req_in(req),
        .mode_in(md), .remote_temp_in(temp), .table_offset_in(ofs), .rdata_out(rd),
        .rvalid_out(rv), .above_out(ab), .duty_out(duty));
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin num_errors++; stop_test(); end
    end
    task automatic cmp(input logic [7:0] g, e);
        checks_done++;
        if (g !== e) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end
    endtask
    task automatic setm(input logic [3:0] m);
        @(posedge clk) md <= m;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk) req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) req <= '0;
    endtask
    task automatic rdc(input logic [7:0] a, e);
        @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) req <= '0;
        #1 cmp({7'h00, rv}, 8'h01);
        cmp(rd, e);
    endtask
    task automatic tchk(input logic [8:0] t, input logic [7:0] ea, ed);
        @(posedge clk) temp <= t;
        repeat (2) @(posedge clk);
        #1 cmp({7'h00, ab}, ea);
        cmp(duty, ed);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_regs;
        rdc(8'h62, 8'h7f);
        rdc(8'h63, 8'h3f);
        wr(8'h62, 8'hff);
        rdc(8'h62, 8'h7f);
        setm(4'b0001);
        wr(8'h62, 8'hff);
        rdc(8'h62, 8'h7f);
        setm(4'b1001);
        rdc(8'h62, 8'hff);
        rdc(8'h70, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_duty;
        wr(8'h63, 8'hc5);
        rdc(8'h63, 8'h05);
        setm(4'b0101);
        rdc(8'h63, 8'h05);
        setm(4'b0111);
        rdc(8'h63, 8'hc5);
        $display("test duty done");
    endtask
    task automatic t_compare;
        setm(4'b0001);
        wr(8'h62, 8'h32);
        tchk(9'd101, 8'h00, 8'h00);
        tchk(9'd102, 8'h01, 8'h05);
        setm(4'b0111);
        tchk(9'd102, 8'h01, 8'hc5);
        tchk(9'd000, 8'h00, 8'h00);
        $display("test compare done");
    endtask
    task automatic t_offset;
        setm(4'b1001);
        wr(8'h62, 8'hc8);
        tchk(9'h0c8, 8'h00, 8'h00);
        tchk(9'h0c9, 8'h01, 8'h05);
        @(posedge clk) ofs <= 9'h014;
        tchk(9'h0dc, 8'h00, 8'h00);
        tchk(9'h0dd, 8'h01, 8'h05);
        @(posedge clk) ofs <= 9'h000;
        $display("test offset done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_duty();
        t_compare();
        t_offset();
        stop_test();
    end
endmodule // fan_lut_entry_ten_tb
`default_nettype wire

// *** tb/lut_entry_properties.sv ***
// Port checker for one fan table entry
`timescale 1ns/1ps
`default_nettype none
module lut_entry_properties (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire lut_entry_pkg::reg_req_s req_in,
    input wire lut_entry_pkg::mode_s mode_in,
    input wire logic [8:0] remote_temp_in,
    input wire logic [7:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic above_out,
    input wire logic [7:0] duty_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_rd(logic [7:0] a);
        req_in.rd && req_in.addr == a;
    endsequence
    a_read_answer: assert property (req_in.rd |=> rvalid_out) else $error("no rvalid");
    a_stray_valid: assert property (!req_in.rd |=> !rvalid_out) else $error("stray rvalid");
    a_rdata_hold: assert property (!req_in.rd |=> $stable(rdata_out)) else $error("rdata moved");
    a_bad_addr: assert property (req_in.rd && req_in.addr > 8'h63 |=> rdata_out == 8'h00)
        else $error("bad addr data");
    a_limit_top_low: assert property (s_rd(8'h62) ##0 !mode_in.hi_res_temp |=> !rdata_out[7])
        else $error("limit bit7 set");
    a_duty_ext_low: assert property (s_rd(8'h63) ##0 !mode_in.hi_res_duty |=> rdata_out[7:6] == 2'h0)
        else $error("duty ext set");
    a_idle_duty_zero: assert property (!above_out |-> duty_out == 8'h00) else $error("idle duty");
    a_cold_not_above: assert property (remote_temp_in == 9'h000 |=> !above_out) else $error("cold above");
    a_ext_gate: assert property (!mode_in.pwm_22k5_sel |=> duty_out[7:6] == 2'h0) else $error("ext on");
endmodule // lut_entry_properties
bind fan_lut_entry_ten lut_entry_properties lut_entry_properties_i (.*);
`default_nettype wire
